// ### bench/rbt_bus_agent.sv
/*
 * far-side bus agent: resolves one shared bus from the block and another driver.
 * assumes its driver inputs change just after clk rises.
 */
`timescale 1ns/10ps

module rbt_bus_agent (
	// clock
	input wire logic clk,
	// block side
	input wire rbt_pkg::rbt_word_t devOut,
	input wire rbt_pkg::rbt_word_t devOe,
	// other driver
	input wire rbt_pkg::rbt_word_t agentVal,
	input wire logic agentEn,
	// resolved wire
	output rbt_pkg::rbt_word_t level
);
	import rbt_pkg::*;
	rbt_word_t lastQ = '0;
	////////////////////////////////////////////////////////////////
	// undriven bits flip every cycle so a stale level never looks valid
	always_comb begin
		level = (devOe & devOut) | (~devOe & (agentEn ? agentVal : ~lastQ));
	end
	always @(posedge clk) begin
		lastQ <= level;
	end
endmodule : rbt_bus_agent

// ### bench/rbt_transceiver_test.sv
/*
 * self-checking bench of the registered bus transceiver.
 * assumes rbt_cfg.svh on the include path and rbt_bus_agent on each bus.
 */
`timescale 1ns/10ps
`include "rbt_cfg.svh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module rbt_transceiver_test;
	import rbt_pkg::*;
	logic coreClk = 1'b0;
	logic resetN = 1'b0;
	rbt_word_t aBusIn, aBusOut, aBusOe, bBusIn, bBusOut, bBusOe, logData;
	rbt_word_t agentA = '0, agentB = '0, vA, vB, vC;
	logic agentAEn = 1'b0, agentBEn = 1'b0, logReady = 1'b1, logValid, logIsBToA, logSpace;
	logic [1:0] abEn = '0, baEnN = 2'b11, abSel = '0, baSel = '0, abClk = '0, baClk = '0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0] adr = '0;
	logic [31:0] wdat = '0, rdat, seed = 32'd58, tmp;
	logic [16:0] expLog[$];
	logic [31:0] expRd[$];
	int fails = 0, nCompared = 0;

	always #10 coreClk = ~coreClk;

	rbt_transceiver rbt_transceiver_i (.core_clk(coreClk), .reset_n(resetN),
		.aBusIn(aBusIn), .aBusOut(aBusOut), .aBusOe(aBusOe),
		.bBusIn(bBusIn), .bBusOut(bBusOut), .bBusOe(bBusOe),
		.aToBDriveEnable(abEn), .bToADriveEnable_n(baEnN), .aToBSourceSelect(abSel),
		.bToASourceSelect(baSel), .aSideCaptureClock(abClk), .bSideCaptureClock(baClk),
		.logValid(logValid), .logReady(logReady), .logData(logData),
		.logIsBToA(logIsBToA), .logSpace(logSpace), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	rbt_bus_agent busA_i (.clk(coreClk), .devOut(aBusOut), .devOe(aBusOe),
		.agentVal(agentA), .agentEn(agentAEn), .level(aBusIn));
	rbt_bus_agent busB_i (.clk(coreClk), .devOut(bBusOut), .devOe(bBusOe),
		.agentVal(agentB), .agentEn(agentBEn), .level(bBusIn));

	////////////////////////////////////////////////////////////////
	function automatic rbt_word_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	task automatic tick(input int n);
		repeat (n) @(posedge coreClk);
	endtask : tick

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	task automatic mode(input logic e, input logic en, input logic s, input logic t);
		abEn <= {2{e}};
		baEnN <= {2{en}};
		abSel <= {2{s}};
		baSel <= {2{t}};
		tick(3);
	endtask : mode

	task automatic cap(input logic a, input logic b);
		abClk <= {2{a}};
		baClk <= {2{b}};
		tick(1);
		abClk <= '0;
		baClk <= '0;
		tick(3);
	endtask : cap

	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= d;
		do begin
			tick(1);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k == 20) begin
			fails++;
			wrap_up();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		tick(1);
	endtask : wb

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		expRd.push_back(e);
		wb(1'b0, ad, 32'h0);
	endtask : rd

	////////////////////////////////////////////////////////////////
	// result watcher: log entries and read answers against the notes
	always @(posedge coreClk) begin
		if (logValid === 1'b1 && logReady === 1'b1) begin
			tmp = {15'h0, expLog.pop_front()};
			`CHK({15'h0, logIsBToA, logData}, tmp)
		end
		if (ack === 1'b1 && we === 1'b0) begin
			tmp = expRd.pop_front();
			`CHK(rdat, tmp)
		end
	end

	// the sequence needs about 115 cycles
	initial begin
		#(20 * 3000);
		fails++;
		wrap_up();
	end

	initial begin
		tick(10);
		resetN <= 1'b1;
		tick(3);
		vA = rnd();
		vB = rnd();
		vC = rnd();
		agentA <= vA;
		agentAEn <= 1'b1;
		mode(1, 1, 0, 0);
		`CHK(bBusOut, vA)
		`CHK(bBusOe, 16'hffff)
		`CHK(aBusOe, 16'h0000)
		expLog.push_back({1'b0, vA});
		cap(1, 0);
		rd(`RBT_ADR_AB, {16'h0, vA});
		done("capture while driving");
		agentB <= vB;
		agentBEn <= 1'b1;
		mode(0, 1, 0, 0);
		expLog.push_back({1'b1, vB});
		cap(0, 1);
		rd(`RBT_ADR_BA, {16'h0, vB});
		done("capture b");
		agentA <= vC;
		agentBEn <= 1'b0;
		mode(1, 1, 0, 0);
		`CHK(bBusOut, vC)
		abSel <= 2'b11;
		repeat (3) begin
			tick(1);
			`CHK(bBusOut === vC || bBusOut === vA, 1'b1)
		end
		`CHK(bBusOut, vA)
		agentA <= vA;
		tick(2);
		abSel <= 2'b00;
		repeat (3) begin
			tick(1);
			`CHK(bBusOut, vA)
		end
		agentAEn <= 1'b0;
		mode(1, 0, 1, 1);
		`CHK(bBusOut, vA)
		`CHK(aBusOut, vB)
		agentB <= vC;
		agentBEn <= 1'b1;
		mode(0, 0, 0, 1);
		`CHK(aBusOut, vB)
		`CHK(bBusOe, 16'h0000)
		mode(0, 0, 0, 0);
		`CHK(aBusOut, vC)
		done("select and enables");
		agentBEn <= 1'b0;
		vA = rnd();
		agentA <= vA;
		agentAEn <= 1'b1;
		mode(1, 1, 0, 0);
		expLog.push_back({1'b0, vA});
		cap(1, 1);
		rd(`RBT_ADR_AB, {16'h0, vA});
		rd(`RBT_ADR_BA, {16'h0, vA});
		rd(`RBT_ADR_STAT, 32'h3f);
		wb(1'b1, `RBT_ADR_STAT, 32'h1);
		done("both stores from a");
		mode(1, 0, 0, 0);
		agentAEn <= 1'b0;
		tick(4);
		`CHK(aBusOut, vA)
		`CHK(bBusOut, vA)
		`CHK(aBusOe, 16'hffff)
		done("mutual hold");
		agentAEn <= 1'b1;
		logReady <= 1'b0;
		mode(1, 1, 0, 0);
		repeat (3) begin
			if (expLog.size() < 2) begin
				expLog.push_back({1'b0, vA});
			end
			cap(1, 0);
		end
		`CHK(logSpace, 1'b0)
		rd(`RBT_ADR_STAT, 32'h1f);
		logReady <= 1'b1;
		tick(4);
		rd(8'h10, 32'h0);
		done("log buffer");
		wb(1'b1, `RBT_ADR_CTRL, 32'h1);
		rd(`RBT_ADR_CTRL, 32'h1);
		abEn <= 2'b01;
		tick(3);
		`CHK(bBusOe, 16'h00ff)
		done("split halves");
		`CHK(expLog.size(), 0)
		`CHK(expRd.size(), 0)
		wrap_up();
	end
endmodule : rbt_transceiver_test

// ### rtl/rbt_buf2.sv
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes an asynchronous active-low reset already released cleanly.
 */
`timescale 1ns/10ps
`include "rbt_cfg.svh"

module rbt_buf2 (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire rbt_pkg::rbt_log_t inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output rbt_pkg::rbt_log_t outData
);
	import rbt_pkg::*;

	rbt_buf_s st_q;
	rbt_buf_s st_d;
	logic doPush;
	logic doPop;

	assign inReady = (st_q.count != 2'h2);
	assign outValid = (st_q.count != 2'h0);
	assign outData = st_q.mem[st_q.rdPtr];
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	always_comb begin
		st_d = st_q;
		if (doPush) begin
			st_d.mem[st_q.wrPtr] = inData;
			st_d.wrPtr = ~st_q.wrPtr;
		end
		if (doPop) begin
			st_d.rdPtr = ~st_q.rdPtr;
		end
		st_d.count = st_q.count + {1'b0, doPush} - {1'b0, doPop};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	bufNoOverfill_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q.count <= 2'h2) else $error("buffer count above two");

endmodule : rbt_buf2

// ### rtl/rbt_cfg.svh
/*
 * constants of the registered bus transceiver: widths, register map,
 * field positions and reset values.
 * assumes inclusion by the package, the design modules and the bench.
 */
// Behaviour
// - each rising capture edge loads the A word into the A-to-B store and the B word into the B-to-A store, whatever the enables and selects.
// - a low select sends live data from the opposite bus, a high select sends the stored word.
// - a select change moves the output between sources with no spurious intermediate value.
// - bus B is driven only while the A-to-B enable is high, bus A only while the active-low B-to-A enable is low.
// - with B driven and the A-to-B select low, bus B follows bus A.
// - with A driven and the B-to-A select low, bus A follows bus B.
// - with A driven, B not driven and the B-to-A select high, bus A carries the B-to-A store.
// - with both driven and both selects high, each bus carries its own stored word at once.
// - with B driven live from A and both capture edges, both stores take the A value.
// - with A driven live from B and both capture edges, both stores take the B value.
// - with both selects low and both ports driven, each bus carries the other's value and the pair keeps its level.
// - the path is 16 bits wide and works as one 16-bit or two independent 8-bit transceivers.
// - capture stays active at all times, also while the port drives.
`ifndef RBT_CFG_SVH
`define RBT_CFG_SVH

`define RBT_HALF_W 8
`define RBT_HALVES 2
`define RBT_BUS_W 16
`define RBT_LOG_W 17
`define RBT_ADR_W 8

`define RBT_ADR_CTRL 8'h00
`define RBT_ADR_STAT 8'h04
`define RBT_ADR_AB 8'h08
`define RBT_ADR_BA 8'h0c

`define RBT_CTRL_SPLIT 0
`define RBT_STAT_OVF 0
`define RBT_STAT_ABKNOWN 1
`define RBT_STAT_BAKNOWN 3
`define RBT_STAT_SPACE 5

`define RBT_SPLIT_RST 1'b0

`endif

// ### rtl/rbt_pkg.sv
/*
 * types of the registered bus transceiver.
 * assumes rbt_cfg.svh on the include path.
 */
`include "rbt_cfg.svh"

package rbt_pkg;

	typedef logic [`RBT_BUS_W-1:0] rbt_word_t;
	typedef logic [`RBT_LOG_W-1:0] rbt_log_t;

	typedef struct packed {
		rbt_word_t abStore;
		rbt_word_t baStore;
		logic [`RBT_HALVES-1:0] abKnown;
		logic [`RBT_HALVES-1:0] baKnown;
		logic [`RBT_HALVES-1:0] abClkPrev;
		logic [`RBT_HALVES-1:0] baClkPrev;
		rbt_word_t aOut;
		rbt_word_t bOut;
		rbt_word_t aOe;
		rbt_word_t bOe;
		rbt_word_t hold;
		logic split;
		logic overflow;
		logic ack;
		logic [31:0] rdData;
	} rbt_state_s;

	typedef struct packed {
		logic [1:0][`RBT_LOG_W-1:0] mem;
		logic wrPtr;
		logic rdPtr;
		logic [1:0] count;
	} rbt_buf_s;

endpackage : rbt_pkg

// ### rtl/rbt_transceiver.sv
/*
 * registered bus transceiver: two 8-bit halves, per-direction store,
 * live or stored source select, drive enables, capture log stream and
 * a classic Wishbone slave for control and status.
 * assumes control pins and bus inputs synchronous to core_clk and the
 * bus wires resolved outside from the out and enable signals.
 */
`timescale 1ns/10ps
`include "rbt_cfg.svh"

module rbt_transceiver (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// bus A
	input wire rbt_pkg::rbt_word_t aBusIn,
	output rbt_pkg::rbt_word_t aBusOut,
	output rbt_pkg::rbt_word_t aBusOe,
	// bus B
	input wire rbt_pkg::rbt_word_t bBusIn,
	output rbt_pkg::rbt_word_t bBusOut,
	output rbt_pkg::rbt_word_t bBusOe,
	// per-half controls
	input wire logic [1:0] aToBDriveEnable,
	input wire logic [1:0] bToADriveEnable_n,
	input wire logic [1:0] aToBSourceSelect,
	input wire logic [1:0] bToASourceSelect,
	input wire logic [1:0] aSideCaptureClock,
	input wire logic [1:0] bSideCaptureClock,
	// capture log stream
	output logic logValid,
	input wire logic logReady,
	output rbt_pkg::rbt_word_t logData,
	output logic logIsBToA,
	output logic logSpace,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`RBT_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import rbt_pkg::*;

	logic rstMeta_q;
	logic rstSync_q;
	rbt_state_s st_q;
	rbt_state_s st_d;
	logic [1:0] abEn, baEn, abSel, baSel, abEdge, baEdge;
	logic [1:0] aLive, bLive, mutual;
	logic [1:0] abEdgePin, baEdgePin;
	rbt_word_t aSamp, bSamp, holdNew;
	logic push;
	rbt_log_t pushData;
	logic bufInReady;
	rbt_log_t bufOut;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstSync_q);

	////////////////////////////////////////////////////////////////////
	// reset release

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// per-half control decode and sample paths

	assign abEdgePin = aSideCaptureClock & ~st_q.abClkPrev;
	assign baEdgePin = bSideCaptureClock & ~st_q.baClkPrev;

	for (genvar h = 0; h < `RBT_HALVES; h++) begin : g_half
		localparam int LO = h * `RBT_HALF_W;
		logic hc;
		// joined mode lets half 0 steer both halves
		assign hc = st_q.split ? 1'(h) : 1'b0;
		assign abEn[h] = aToBDriveEnable[hc];
		assign baEn[h] = ~bToADriveEnable_n[hc];
		assign abSel[h] = aToBSourceSelect[hc];
		assign baSel[h] = bToASourceSelect[hc];
		assign abEdge[h] = abEdgePin[hc];
		assign baEdge[h] = baEdgePin[hc];
		assign bLive[h] = abEn[h] && !abSel[h];
		assign aLive[h] = baEn[h] && !baSel[h];
		assign mutual[h] = aLive[h] && bLive[h];
		// a driven bus carries what this block sends, so sample that
		assign aSamp[LO +: 8] = mutual[h] ? holdNew[LO +: 8] :
			aLive[h] ? bBusIn[LO +: 8] : aBusIn[LO +: 8];
		assign bSamp[LO +: 8] = mutual[h] ? holdNew[LO +: 8] :
			bLive[h] ? aBusIn[LO +: 8] : bBusIn[LO +: 8];
		// an outside driver is seen as a bus level that differs from ours
		assign holdNew[LO +: 8] = (aBusIn[LO +: 8] != st_q.aOut[LO +: 8]) ? aBusIn[LO +: 8] :
			(bBusIn[LO +: 8] != st_q.bOut[LO +: 8]) ? bBusIn[LO +: 8] :
			st_q.hold[LO +: 8];

		abCapture_a: assert property (abEdge[h] && !aLive[h] && !mutual[h]
			|=> st_q.abStore[LO +: 8] == $past(aBusIn[LO +: 8]))
			else $error("A-to-B store missed its capture");
		capWhileDrive_a: assert property (baEdge[h] && baEn[h] && baSel[h] && !bLive[h]
			|=> st_q.baStore[LO +: 8] == $past(bBusIn[LO +: 8]))
			else $error("B-to-A capture lost while A driven");
		storedToB_a: assert property (abEn[h] && abSel[h]
			|=> bBusOut[LO +: 8] == $past(st_q.abStore[LO +: 8]))
			else $error("stored word not sent to B");
		driveB_a: assert property (1'b1
			|=> bBusOe[LO +: 8] == {8{$past(abEn[h])}})
			else $error("B enable does not track control");
		driveA_a: assert property (1'b1
			|=> aBusOe[LO +: 8] == {8{$past(baEn[h])}})
			else $error("A enable does not track control");
		liveToB_a: assert property (bLive[h] && !aLive[h]
			|=> bBusOut[LO +: 8] == $past(aBusIn[LO +: 8]))
			else $error("B does not follow A");
		liveToA_a: assert property (aLive[h] && !bLive[h]
			|=> aBusOut[LO +: 8] == $past(bBusIn[LO +: 8]))
			else $error("A does not follow B");
		storedToA_a: assert property (baEn[h] && baSel[h] && !abEn[h]
			|=> aBusOut[LO +: 8] == $past(st_q.baStore[LO +: 8]) && bBusOe[LO +: 8] == 8'h00)
			else $error("stored B word not on A");
		bothStored_a: assert property (abEn[h] && abSel[h] && baEn[h] && baSel[h]
			|=> aBusOut[LO +: 8] == $past(st_q.baStore[LO +: 8])
			&& bBusOut[LO +: 8] == $past(st_q.abStore[LO +: 8]))
			else $error("both stored words not driven");
		shareA_a: assert property (bLive[h] && !aLive[h] && abEdge[h] && baEdge[h]
			|=> st_q.baStore[LO +: 8] == $past(aBusIn[LO +: 8])
			&& st_q.abStore[LO +: 8] == $past(aBusIn[LO +: 8]))
			else $error("stores did not both take A");
		shareB_a: assert property (aLive[h] && !bLive[h] && abEdge[h] && baEdge[h]
			|=> st_q.abStore[LO +: 8] == $past(bBusIn[LO +: 8])
			&& st_q.baStore[LO +: 8] == $past(bBusIn[LO +: 8]))
			else $error("stores did not both take B");
		noGlitch_a: assert property ($changed(abSel[h]) && abEn[h] && $past(abEn[h])
			&& !aLive[h] && !abEdge[h] && !$past(abEdge[h]) && $stable(aBusIn[LO +: 8])
			&& aBusIn[LO +: 8] == st_q.abStore[LO +: 8]
			|=> $stable(bBusOut[LO +: 8]))
			else $error("B output moved on select change");
		mutual_a: assert property (mutual[h]
			|=> aBusOut[LO +: 8] == bBusOut[LO +: 8]
			&& aBusOe[LO +: 8] == 8'hff && bBusOe[LO +: 8] == 8'hff)
			else $error("mutual drive not balanced");
		mutualHold_a: assert property (mutual[h] && $past(mutual[h])
			&& aBusIn[LO +: 8] == st_q.aOut[LO +: 8] && bBusIn[LO +: 8] == st_q.bOut[LO +: 8]
			|=> $stable(aBusOut[LO +: 8]))
			else $error("mutual hold lost its level");
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_d = st_q;
		st_d.abClkPrev = aSideCaptureClock;
		st_d.baClkPrev = bSideCaptureClock;
		for (int h = 0; h < `RBT_HALVES; h++) begin
			// capture ignores enables and selects
			if (abEdge[h]) begin
				st_d.abStore[h*8 +: 8] = aSamp[h*8 +: 8];
				st_d.abKnown[h] = 1'b1;
			end
			if (baEdge[h]) begin
				st_d.baStore[h*8 +: 8] = bSamp[h*8 +: 8];
				st_d.baKnown[h] = 1'b1;
			end
			// registered outputs switch source in one step
			st_d.bOut[h*8 +: 8] = abSel[h] ? st_q.abStore[h*8 +: 8] : aBusIn[h*8 +: 8];
			st_d.aOut[h*8 +: 8] = baSel[h] ? st_q.baStore[h*8 +: 8] : bBusIn[h*8 +: 8];
			st_d.bOe[h*8 +: 8] = {8{abEn[h]}};
			st_d.aOe[h*8 +: 8] = {8{baEn[h]}};
			// track the pair level so a mutual hold starts from the last live value
			st_d.hold[h*8 +: 8] = aLive[h] ? bBusIn[h*8 +: 8] : aBusIn[h*8 +: 8];
			if (mutual[h]) begin
				st_d.hold[h*8 +: 8] = holdNew[h*8 +: 8];
				st_d.aOut[h*8 +: 8] = holdNew[h*8 +: 8];
				st_d.bOut[h*8 +: 8] = holdNew[h*8 +: 8];
			end
		end
		// log the store that changed; A-to-B wins a tie
		push = 1'b0;
		pushData = '0;
		if (|abEdge) begin
			push = 1'b1;
			pushData = {1'b0, st_d.abStore};
		end else if (|baEdge) begin
			push = 1'b1;
			pushData = {1'b1, st_d.baStore};
		end
		// wishbone: answer one cycle after the request, write at the ack edge
		st_d.ack = 1'b0;
		if (wb_cyc_i && wb_stb_i && !st_q.ack) begin
			st_d.ack = 1'b1;
			unique case (wb_adr_i)
				`RBT_ADR_CTRL: st_d.rdData = {31'h0, st_q.split};
				`RBT_ADR_STAT: st_d.rdData = {26'h0, bufInReady, st_q.baKnown,
					st_q.abKnown, st_q.overflow};
				`RBT_ADR_AB: st_d.rdData = {16'h0, st_q.abStore};
				`RBT_ADR_BA: st_d.rdData = {16'h0, st_q.baStore};
				default: st_d.rdData = 32'h0;
			endcase
		end
		if (wb_cyc_i && wb_stb_i && st_q.ack && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == `RBT_ADR_CTRL) begin
				st_d.split = wb_dat_i[`RBT_CTRL_SPLIT];
			end
			if (wb_adr_i == `RBT_ADR_STAT && wb_dat_i[`RBT_STAT_OVF]) begin
				st_d.overflow = 1'b0;
			end
		end
		// a lost log entry sets after the clear, so it is never missed
		if ((push && !bufInReady) || (|abEdge && |baEdge)) begin
			st_d.overflow = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register; stores keep no reset value

	always_ff @(posedge core_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			st_q.abKnown <= '0;
			st_q.baKnown <= '0;
			st_q.abClkPrev <= '0;
			st_q.baClkPrev <= '0;
			st_q.aOut <= '0;
			st_q.bOut <= '0;
			st_q.aOe <= '0;
			st_q.bOe <= '0;
			st_q.hold <= '0;
			st_q.split <= `RBT_SPLIT_RST;
			st_q.overflow <= 1'b0;
			st_q.ack <= 1'b0;
			st_q.rdData <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs and log buffer

	assign aBusOut = st_q.aOut;
	assign aBusOe = st_q.aOe;
	assign bBusOut = st_q.bOut;
	assign bBusOe = st_q.bOe;
	assign wb_dat_o = st_q.rdData;
	assign wb_ack_o = st_q.ack;
	assign logSpace = bufInReady;
	assign logData = bufOut[`RBT_BUS_W-1:0];
	assign logIsBToA = bufOut[`RBT_LOG_W-1];

	rbt_buf2 u_buf (
		.clk(core_clk),
		.rst_n(rstSync_q),
		.inValid(push),
		.inReady(bufInReady),
		.inData(pushData),
		.outValid(logValid),
		.outReady(logReady),
		.outData(bufOut)
	);

	splitTie_a: assert property (!st_q.split
		|-> abEn[1] == abEn[0] && baSel[1] == baSel[0] && abEdge[1] == abEdge[0])
		else $error("joined halves disagree");
	ackOnce_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

endmodule : rbt_transceiver
